// ===== verilog/dcsw_core.sv
// drive control word decode, status word assembly and coil read packing
`timescale 1ns/1ps
module dcsw_core
  import dcsw_pkg::*;
#(
  parameter int OC_DELAY = OC_TRIP_DELAY_CYC // overcurrent trip delay in cycles
) (
  input wire logic mclk, // 100 MHz clock
  input wire logic rstn, // synchronous reset, active low
  input wire logic hsel, // AHB slave select
  input wire logic [31:0] haddr, // AHB address
  input wire logic [1:0] htrans, // AHB transfer type
  input wire logic hwrite, // AHB write
  input wire logic [2:0] hsize, // AHB size, word only
  input wire logic [31:0] hwdata, // AHB write data
  input wire logic hready, // AHB bus ready
  output logic [31:0] hrdata, // AHB read data
  output logic hreadyout, // AHB slave ready
  output logic hresp, // AHB response, always OKAY
  input wire logic tripIn, // drive fault has tripped
  input wire logic tripLockIn, // trip lock condition
  input wire logic warnIn, // any warning
  input wire logic atRefIn, // speed equals reference
  input wire logic localStopIn, // local stop active
  input wire logic handModeIn, // hand mode
  input wire logic dcVoltIn, // DC link voltage out of band
  input wire logic thermalIn, // motor/converter/thermistor over temperature
  input wire logic coastPinN, // coast input, low coasts
  input wire logic startPin, // digital start input
  input wire logic reversePin, // digital reversing input
  input wire logic [15:0] outFreq, // present output frequency, signed
  input wire logic [15:0] outCurrent, // present output current
  output logic [1:0] activeSetup, // selected setup minus one
  output logic reverseCmd, // reversed rotation requested
  output logic [15:0] refMagnitude, // magnitude of speed reference
  output logic tripResetPulse, // one-cycle trip reset
  output logic [15:0] statusWord, // assembled status word
  output logic tripOut // converter tripped
);
  import dcsw_pkg::*;

  dcsw_state_t r;
  dcsw_state_t n;
  logic tripFlop;
  logic serialOk;
  logic coastCmd;
  logic running;
  logic curHigh;
  logic ocFire;
  logic accept;
  logic resetEdge;
  logic wrCtrl;
  logic wrCoil;
  logic [15:0] sw;
  logic [NPIN-1:0] pinVec;
  logic [NPIN-1:0] agree;
  logic [63:0] image;
  logic [63:0] mask;
  logic [7:0] cStart;
  logic [7:0] cCount;
  logic [7:0] cFunc;
  logic [8:0] cEnd;
  logic revSel;
  logic busRev;
  logic supported;

  assign pinVec = {reversePin, startPin, coastPinN, thermalIn, dcVoltIn, handModeIn,
    localStopIn, atRefIn, warnIn, tripLockIn, tripIn};

  always_comb
  begin
    n = r;
    // pins settle when the 2nd and 3rd stages agree; stage 1 feeds stage 2 only
    agree = ~(r.s2 ^ r.s3);
    n.s1 = pinVec;
    n.s2 = r.s1;
    n.s3 = r.s2;
    n.pins = (agree & r.s3) | (~agree & r.pins);

    serialOk = ~r.pins[PIN_LOCAL_STOP] & ~r.pins[PIN_HAND];
    coastCmd = r.ctrlSeen & ~r.ctrlAct[CW_COAST];
    running = (r.ctrlSeen & r.ctrlAct[CW_START]) | r.pins[PIN_START]
      | ($signed(outFreq) > $signed(16'h0000));
    curHigh = outCurrent > r.ceiling;

    sw = 16'h0000;
    sw[SW_CTRL_READY] = ~r.tripped;
    sw[SW_DRIVE_READY] = ~r.tripped & (~r.pins[PIN_COAST_N] | coastCmd);
    sw[SW_STANDBY] = ~r.tripped & r.pins[PIN_COAST_N] & ~coastCmd & ~running;
    sw[SW_TRIP] = r.tripped;
    sw[SW_TRIP_LOCK] = r.pins[PIN_TRIP_LOCK];
    sw[SW_WARNING] = r.pins[PIN_WARN];
    sw[SW_AT_REF] = r.pins[PIN_AT_REF];
    sw[SW_SERIAL] = serialOk;
    sw[SW_IN_RANGE] = ($signed(outFreq) > $signed(r.fLow))
      & ($signed(outFreq) < $signed(r.fHigh));
    sw[SW_RUNNING] = running;
    sw[SW_VOLTAGE] = r.pins[PIN_DC_VOLT];
    sw[SW_CUR_LIMIT] = curHigh;
    sw[SW_THERMAL] = r.pins[PIN_THERMAL];
    n.statusWord = sw;

    // counter holds at the end so a persistent overload trips only once until a trip reset clears the counter
    ocFire = 1'b0;
    if (!curHigh)
      n.ocCount = 32'h0000_0000;
    else if (r.ocCount < 32'(OC_DELAY - 1))
      n.ocCount = r.ocCount + 32'h0000_0001;
    else if (r.ocCount == 32'(OC_DELAY - 1))
    begin
      n.ocCount = 32'(OC_DELAY);
      ocFire = 1'b1;
    end

    wrCtrl = (r.phase == BUS_DATA) & r.write & (r.addr == OFF_CTRL);
    wrCoil = (r.phase == BUS_DATA) & r.write & (r.addr == OFF_COILCMD);
    accept = wrCtrl & hwdata[CW_VALID] & serialOk;
    resetEdge = accept & hwdata[CW_RESET] & ~r.prevReset;
    n.tripResetPulse = resetEdge;
    if (accept)
    begin
      n.ctrlAct = hwdata[15:0];
      n.ctrlSeen = 1'b1;
      n.prevReset = hwdata[CW_RESET];
    end
    if (resetEdge)
      n.ocCount = 32'h0000_0000;
    // a new fault in the reset cycle keeps the trip
    n.tripped = r.pins[PIN_TRIP] | ocFire | (r.tripped & ~resetEdge);

    n.activeSetup = r.multiSetup ? r.ctrlAct[CW_SETUP_LSB+1:CW_SETUP_LSB] : 2'b00;
    busRev = r.ctrlSeen & r.ctrlAct[CW_REVERSE];
    unique case (r.revSrc)
      REV_DIGITAL: revSel = r.pins[PIN_REVERSE];
      REV_BUS: revSel = busRev;
      REV_AND: revSel = busRev & r.pins[PIN_REVERSE];
      REV_OR: revSel = busRev | r.pins[PIN_REVERSE];
    endcase
    n.reverseCmd = revSel ^ r.speedRef[15];
    n.refMagnitude = r.speedRef[15] ? (~r.speedRef + 16'h0001) : r.speedRef;

    // coil command decode
    cStart = hwdata[CC_START_LSB+:8];
    cCount = hwdata[CC_COUNT_LSB+:8];
    cFunc = hwdata[CC_FUNC_LSB+:8];
    cEnd = {1'b0, cStart} + {1'b0, cCount};
    image = {outFreq, r.statusWord, r.speedRef, r.ctrlAct};
    mask = (cCount >= 8'(COIL_SPACE)) ? 64'hFFFF_FFFF_FFFF_FFFF
      : ((64'h0000_0000_0000_0001 << cCount) - 64'h0000_0000_0000_0001);
    supported = (cFunc == FC_READ_COILS) | (cFunc == FC_FORCE_COIL)
      | (cFunc == FC_FORCE_COILS) | (cFunc == FC_READ_HOLD)
      | (cFunc == FC_PRESET_REG) | (cFunc == FC_PRESET_REGS);
    if (wrCoil)
    begin
      n.coilCmd = hwdata[24:0];
      n.fcUnsup = ~supported;
      n.coilErr = 1'b0;
      n.bcastIgnored = 1'b0;
      n.coilDone = 1'b0;
      if (cFunc == FC_READ_COILS)
      begin
        if (hwdata[CC_BCAST])
          n.bcastIgnored = 1'b1;
        else if ((cCount == 8'h00) || (cEnd > 9'(COIL_SPACE)))
          n.coilErr = 1'b1;
        else
        begin
          n.coilData = (image >> cStart) & mask;
          n.byteCount = 4'((({1'b0, cCount} + 9'h007) >> 3));
          n.coilDone = 1'b1;
        end
      end
    end

    // AHB-Lite slave: every transfer takes one wait state
    n.hresp = 1'b0;
    unique case (r.phase)
      BUS_ADDR:
      begin
        if (hsel && hready && htrans[1])
        begin
          n.phase = BUS_DATA;
          n.addr = (haddr[31:8] == 24'h000000) ? haddr[7:0] : OFF_UNMAPPED;
          n.write = hwrite;
          n.hreadyout = 1'b0;
        end
      end
      BUS_DATA:
      begin
        n.phase = BUS_ADDR;
        n.hreadyout = 1'b1;
        n.hrdata = 32'h0000_0000;
        if (r.write)
        begin
          unique case (r.addr)
            OFF_CTRL: n.ctrlRaw = hwdata[15:0];
            OFF_REF: n.speedRef = hwdata[15:0];
            OFF_CFG:
            begin
              n.multiSetup = hwdata[CFG_MULTI];
              n.revSrc = dcsw_revsrc_t'(hwdata[CFG_REVSRC_LSB+:2]);
            end
            OFF_FLIM:
            begin
              n.fLow = hwdata[15:0];
              n.fHigh = hwdata[31:16];
            end
            OFF_CEIL: n.ceiling = hwdata[15:0];
            default: n.hrdata = 32'h0000_0000;
          endcase
        end
        else
        begin
          unique case (r.addr)
            OFF_CTRL: n.hrdata = {16'h0000, r.ctrlRaw};
            OFF_REF: n.hrdata = {16'h0000, r.speedRef};
            OFF_CFG: n.hrdata = {29'h0000_0000, r.revSrc, r.multiSetup};
            OFF_STATUS: n.hrdata = {16'h0000, r.statusWord};
            OFF_OUTFREQ: n.hrdata = {16'h0000, outFreq};
            OFF_FLIM: n.hrdata = {r.fHigh, r.fLow};
            OFF_CEIL: n.hrdata = {16'h0000, r.ceiling};
            OFF_COILCMD: n.hrdata = {7'h00, r.coilCmd};
            OFF_COILRSP0: n.hrdata = r.coilData[31:0];
            OFF_COILRSP1: n.hrdata = r.coilData[63:32];
            OFF_COILINFO: n.hrdata = {24'h000000, r.bcastIgnored, r.fcUnsup, r.coilErr,
              r.coilDone, r.byteCount};
            default: n.hrdata = 32'h0000_0000;
          endcase
        end
      end
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      r <= '0;
      r.phase <= BUS_ADDR;
      r.hreadyout <= 1'b1;
      r.ctrlRaw <= CTRL_RST;
      r.ctrlAct <= CTRL_RST;
      r.speedRef <= REF_RST;
      r.revSrc <= REV_DIGITAL;
      r.fLow <= FLOW_RST;
      r.fHigh <= FHIGH_RST;
      r.ceiling <= CEIL_RST;
      // coast pin idles high; stages start at 1 so no false coast follows reset
      r.s1[PIN_COAST_N] <= 1'b1;
      r.s2[PIN_COAST_N] <= 1'b1;
      r.s3[PIN_COAST_N] <= 1'b1;
      r.pins[PIN_COAST_N] <= 1'b1;
    end
    else
      r <= n;
  end

  assign tripFlop = r.tripped;
  assign hrdata = r.hrdata;
  assign hreadyout = r.hreadyout;
  assign hresp = r.hresp;
  assign activeSetup = r.activeSetup;
  assign reverseCmd = r.reverseCmd;
  assign refMagnitude = r.refMagnitude;
  assign tripResetPulse = r.tripResetPulse;
  assign statusWord = r.statusWord;
  assign tripOut = tripFlop;

  property p_setup;
    @(posedge mclk) disable iff (!rstn)
    r.multiSetup |=> activeSetup == $past(r.ctrlAct[CW_SETUP_LSB+1:CW_SETUP_LSB]);
  endproperty
  a_setup: assert property (p_setup) else $error("setup select wrong");

  property p_rev;
    @(posedge mclk) disable iff (!rstn)
    (r.revSrc == REV_BUS) |=> reverseCmd == $past(busRev ^ r.speedRef[15]);
  endproperty
  a_rev: assert property (p_rev) else $error("reverse request wrong");

  property p_trip_bits;
    @(posedge mclk) disable iff (!rstn)
    r.tripped |=> statusWord[SW_TRIP] && !statusWord[SW_CTRL_READY];
  endproperty
  a_trip_bits: assert property (p_trip_bits) else $error("trip bits wrong");

  property p_unused;
    @(posedge mclk) disable iff (!rstn)
    !statusWord[4] && !statusWord[5] && !statusWord[12];
  endproperty
  a_unused: assert property (p_unused) else $error("unused status bit set");

  property p_invalid;
    @(posedge mclk) disable iff (!rstn)
    (wrCtrl && (!hwdata[CW_VALID] || !serialOk)) |=> $stable(r.ctrlAct);
  endproperty
  a_invalid: assert property (p_invalid) else $error("ignored ctrl word used");

  property p_reset_edge;
    @(posedge mclk) disable iff (!rstn)
    tripResetPulse |-> r.prevReset && !$past(r.prevReset);
  endproperty
  a_reset_edge: assert property (p_reset_edge) else $error("reset not on edge");

  property p_bcast;
    @(posedge mclk) disable iff (!rstn)
    (wrCoil && cFunc == FC_READ_COILS && hwdata[CC_BCAST])
      |=> $stable(r.coilData) && r.bcastIgnored && !r.coilDone;
  endproperty
  a_bcast: assert property (p_bcast) else $error("broadcast read acted on");

  property p_oc_trip;
    @(posedge mclk) disable iff (!rstn)
    (curHigh && r.ocCount == 32'(OC_DELAY - 1)) |=> r.tripped ##1 statusWord[SW_TRIP];
  endproperty
  a_oc_trip: assert property (p_oc_trip) else $error("overcurrent did not trip");

  property p_pack;
    @(posedge mclk) disable iff (!rstn)
    (wrCoil && cFunc == FC_READ_COILS && !hwdata[CC_BCAST] && cCount == 8'h08
      && cEnd <= 9'(COIL_SPACE)) |=> r.byteCount == 4'h1 && r.coilData[63:8] == 56'h0;
  endproperty
  a_pack: assert property (p_pack) else $error("coil packing wrong");

  property p_wait;
    @(posedge mclk) disable iff (!rstn)
    (r.phase == BUS_DATA) |-> !hreadyout ##1 hreadyout;
  endproperty
  a_wait: assert property (p_wait) else $error("bus wait state wrong");

  property p_local;
    @(posedge mclk) disable iff (!rstn)
    (r.pins[PIN_LOCAL_STOP] || r.pins[PIN_HAND]) |=> !statusWord[SW_SERIAL];
  endproperty
  a_local: assert property (p_local) else $error("serial bit set in local mode");

  property p_range;
    @(posedge mclk) disable iff (!rstn)
    ($signed(outFreq) >= $signed(r.fHigh)) |=> !statusWord[SW_IN_RANGE];
  endproperty
  a_range: assert property (p_range) else $error("range bit set at limit");

  property p_cur_limit;
    @(posedge mclk) disable iff (!rstn)
    (outCurrent > r.ceiling) |=> statusWord[SW_CUR_LIMIT];
  endproperty
  a_cur_limit: assert property (p_cur_limit) else $error("current limit bit clear");

  c_status_read: cover property (@(posedge mclk) disable iff (!rstn)
    wrCoil && cFunc == FC_READ_COILS && cStart == COIL_STATUS_START
      && cCount == COIL_STATUS_COUNT);
  c_reset: cover property (@(posedge mclk) disable iff (!rstn) tripResetPulse);
  c_oc: cover property (@(posedge mclk) disable iff (!rstn) ocFire);
endmodule

// ===== verilog/dcsw_pkg.sv
// constants, types and register map for the drive control/status word block
package dcsw_pkg;
  // register byte offsets on the AHB-Lite bus
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_REF = 8'h04;
  localparam logic [7:0] OFF_CFG = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0C;
  localparam logic [7:0] OFF_OUTFREQ = 8'h10;
  localparam logic [7:0] OFF_FLIM = 8'h14;
  localparam logic [7:0] OFF_CEIL = 8'h18;
  localparam logic [7:0] OFF_COILCMD = 8'h1C;
  localparam logic [7:0] OFF_COILRSP0 = 8'h20;
  localparam logic [7:0] OFF_COILRSP1 = 8'h24;
  localparam logic [7:0] OFF_COILINFO = 8'h28;
  localparam logic [7:0] OFF_UNMAPPED = 8'hFF;
  // control word bit positions
  localparam int CW_COAST = 3;
  localparam int CW_START = 6;
  localparam int CW_RESET = 7;
  localparam int CW_VALID = 10;
  localparam int CW_SETUP_LSB = 13;
  localparam int CW_REVERSE = 15;
  // status word bit positions
  localparam int SW_CTRL_READY = 0;
  localparam int SW_DRIVE_READY = 1;
  localparam int SW_STANDBY = 2;
  localparam int SW_TRIP = 3;
  localparam int SW_TRIP_LOCK = 6;
  localparam int SW_WARNING = 7;
  localparam int SW_AT_REF = 8;
  localparam int SW_SERIAL = 9;
  localparam int SW_IN_RANGE = 10;
  localparam int SW_RUNNING = 11;
  localparam int SW_VOLTAGE = 13;
  localparam int SW_CUR_LIMIT = 14;
  localparam int SW_THERMAL = 15;
  // configuration register fields
  localparam int CFG_MULTI = 0;
  localparam int CFG_REVSRC_LSB = 1;
  // coil command register fields
  localparam int CC_START_LSB = 0;
  localparam int CC_COUNT_LSB = 8;
  localparam int CC_FUNC_LSB = 16;
  localparam int CC_BCAST = 24;
  // supported function codes
  localparam logic [7:0] FC_READ_COILS = 8'h01;
  localparam logic [7:0] FC_FORCE_COIL = 8'h05;
  localparam logic [7:0] FC_FORCE_COILS = 8'h0F;
  localparam logic [7:0] FC_READ_HOLD = 8'h03;
  localparam logic [7:0] FC_PRESET_REG = 8'h06;
  localparam logic [7:0] FC_PRESET_REGS = 8'h10;
  // coil space: ctrl 0-15, reference 16-31, status 32-47, output freq 48-63
  localparam int COIL_SPACE = 64;
  localparam logic [7:0] COIL_STATUS_START = 8'h20;
  localparam logic [7:0] COIL_STATUS_COUNT = 8'h10;
  // synchronised pin indices
  localparam int PIN_TRIP = 0;
  localparam int PIN_TRIP_LOCK = 1;
  localparam int PIN_WARN = 2;
  localparam int PIN_AT_REF = 3;
  localparam int PIN_LOCAL_STOP = 4;
  localparam int PIN_HAND = 5;
  localparam int PIN_DC_VOLT = 6;
  localparam int PIN_THERMAL = 7;
  localparam int PIN_COAST_N = 8;
  localparam int PIN_START = 9;
  localparam int PIN_REVERSE = 10;
  localparam int NPIN = 11;
  // reset values
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [15:0] REF_RST = 16'h0000;
  localparam logic [15:0] FLOW_RST = 16'h0000;
  localparam logic [15:0] FHIGH_RST = 16'h4000;
  localparam logic [15:0] CEIL_RST = 16'hFFFF;
  // overcurrent trip delay
  localparam int CLK_MHZ = 100;
  localparam int OC_TRIP_DELAY_US = 1000;
  localparam int OC_TRIP_DELAY_CYC = OC_TRIP_DELAY_US * CLK_MHZ;

  typedef enum logic [1:0] {
    REV_DIGITAL = 2'b00,
    REV_BUS = 2'b01,
    REV_AND = 2'b10,
    REV_OR = 2'b11
  } dcsw_revsrc_t;

  typedef enum logic {
    BUS_ADDR = 1'b0,
    BUS_DATA = 1'b1
  } dcsw_bus_t;

  typedef struct packed {
    dcsw_bus_t phase;
    logic [7:0] addr;
    logic write;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic [15:0] ctrlRaw;
    logic [15:0] ctrlAct;
    logic ctrlSeen;
    logic prevReset;
    logic [15:0] speedRef;
    logic multiSetup;
    dcsw_revsrc_t revSrc;
    logic [15:0] fLow;
    logic [15:0] fHigh;
    logic [15:0] ceiling;
    logic [24:0] coilCmd;
    logic [63:0] coilData;
    logic [3:0] byteCount;
    logic coilDone;
    logic coilErr;
    logic fcUnsup;
    logic bcastIgnored;
    logic tripped;
    logic [31:0] ocCount;
    logic [NPIN-1:0] s1;
    logic [NPIN-1:0] s2;
    logic [NPIN-1:0] s3;
    logic [NPIN-1:0] pins;
    logic [1:0] activeSetup;
    logic reverseCmd;
    logic [15:0] refMagnitude;
    logic tripResetPulse;
    logic [15:0] statusWord;
  } dcsw_state_t;
endpackage

// ===== dv/dcsw_master.sv
// partner model: AHB-Lite master standing in for the serial-link master
`timescale 1ns/1ps
module dcsw_master (
  input wire logic mclk, // 100 MHz clock
  output logic hsel, // slave select
  output logic [31:0] haddr, // byte address
  output logic [1:0] htrans, // transfer type
  output logic hwrite, // write strobe
  output logic [2:0] hsize, // always a word
  output logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready
  input wire logic [31:0] hrdata // read data
);
  initial
  begin
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
  end
  // no bound of its own: only the bench watchdog ends a stuck wait
  task automatic waitReady();
    @(posedge mclk);
    while (hready !== 1'b1)
      @(posedge mclk);
  endtask
  // entered just after a rising edge; returns at the edge that ends the data phase
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
    output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h000000, a};
    hwrite <= wr;
    waitReady();
    htrans <= 2'b00;
    hwdata <= wd;
    waitReady();
    rd = hrdata;
  endtask
endmodule

// ===== dv/drive_control_status_words_test.sv
// self-checking bench for the drive control/status word block
`timescale 1ns/1ps
module drive_control_status_words_test;
  import dcsw_pkg::*;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic hsel, hwrite, hreadyout, hresp, reverseCmd, tripResetPulse, tripOut;
  logic [31:0] haddr, hwdata, hrdata, v;
  logic [1:0] htrans, activeSetup;
  logic [2:0] hsize;
  logic [15:0] refMagnitude, statusWord;
  logic tripIn = 1'b0, tripLockIn = 1'b0, warnIn = 1'b0, atRefIn = 1'b0;
  logic localStopIn = 1'b0, handModeIn = 1'b0, dcVoltIn = 1'b0, thermalIn = 1'b0;
  logic coastPinN = 1'b1, startPin = 1'b0, reversePin = 1'b0;
  logic [15:0] outFreq = 16'h0000, outCurrent = 16'h0000;
  int n_mismatch = 0, n_compared = 0, nPulse = 0;
  localparam int OCD = 20;

  initial
  begin
    forever #5 mclk = ~mclk;
  end

  dcsw_master m (.mclk(mclk), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata));

  dcsw_core #(.OC_DELAY(OCD)) uut (.mclk(mclk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .tripIn(tripIn),
    .tripLockIn(tripLockIn), .warnIn(warnIn), .atRefIn(atRefIn), .localStopIn(localStopIn),
    .handModeIn(handModeIn), .dcVoltIn(dcVoltIn), .thermalIn(thermalIn),
    .coastPinN(coastPinN), .startPin(startPin), .reversePin(reversePin), .outFreq(outFreq),
    .outCurrent(outCurrent), .activeSetup(activeSetup), .reverseCmd(reverseCmd),
    .refMagnitude(refMagnitude), .tripResetPulse(tripResetPulse), .statusWord(statusWord),
    .tripOut(tripOut));

  always @(posedge mclk)
  begin
    if (tripResetPulse === 1'b1)
      nPulse++;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    m.xfer(1'b1, a, d, x);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    m.xfer(1'b0, a, 32'h00000000, d);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] x;
    rd(a, x);
    check(x, e);
  endtask
  // launch a coil query and let the packer finish
  task automatic coil(input logic [31:0] cmd);
    wr(OFF_COILCMD, cmd);
    cyc(10);
    rd(OFF_COILINFO, v);
  endtask
  task automatic give_verdict();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // the whole run is a few hundred cycles
  initial
  begin
    #200000;
    n_mismatch++;
    give_verdict();
  end

  initial
  begin
    cyc(2);
    rstn <= 1'b1;
    cyc(3);
    rchk(OFF_FLIM, 32'h40000000);
    rchk(OFF_CEIL, 32'h0000FFFF);
    rchk(OFF_UNMAPPED, 32'h00000000);
    rchk(OFF_STATUS, 32'h00000205);
    check({16'h0, statusWord}, 32'h00000205);
    $display("test reset done");

    tripLockIn <= 1'b1;
    warnIn <= 1'b1;
    atRefIn <= 1'b1;
    dcVoltIn <= 1'b1;
    thermalIn <= 1'b1;
    outFreq <= 16'h2000;
    cyc(8);
    rchk(OFF_STATUS, 32'h0000AFC1);
    rchk(OFF_OUTFREQ, 32'h00002000);
    outFreq <= 16'h4000;
    cyc(4);
    rchk(OFF_STATUS, 32'h0000ABC1);
    outFreq <= 16'hC000;
    cyc(4);
    rchk(OFF_STATUS, 32'h0000A3C5);
    {tripLockIn, warnIn, atRefIn, dcVoltIn, thermalIn} <= 5'b00000;
    outFreq <= 16'h0000;
    startPin <= 1'b1;
    cyc(8);
    rchk(OFF_STATUS, 32'h00000A01);
    startPin <= 1'b0;
    cyc(8);
    $display("test pins done");

    wr(OFF_CFG, 32'h00000001);
    for (int s = 0; s < 4; s++)
    begin
      wr(OFF_CTRL, 32'h00000408 | (s << 13));
      cyc(3);
      check({30'h0, activeSetup}, s);
    end
    wr(OFF_CTRL, 32'h00000008);
    cyc(3);
    check({30'h0, activeSetup}, 32'h3);
    localStopIn <= 1'b1;
    cyc(8);
    wr(OFF_CTRL, 32'h00000408);
    cyc(3);
    check({30'h0, activeSetup}, 32'h3);
    rchk(OFF_STATUS, 32'h00000005);
    localStopIn <= 1'b0;
    cyc(8);
    wr(OFF_CTRL, 32'h00000400);
    cyc(3);
    rchk(OFF_STATUS, 32'h00000203);
    wr(OFF_CTRL, 32'h00000408);
    cyc(3);
    rchk(OFF_STATUS, 32'h00000205);
    wr(OFF_CFG, 32'h00000000);
    wr(OFF_CTRL, 32'h00006408);
    cyc(3);
    check({30'h0, activeSetup}, 32'h0);
    $display("test setup done");

    wr(OFF_REF, 32'h00002000);
    for (int s = 0; s < 4; s++)
    begin
      wr(OFF_CFG, s << 1);
      wr(OFF_CTRL, 32'h00008408);
      cyc(3);
      check({31'h0, reverseCmd}, s & 1);
    end
    check({16'h0, refMagnitude}, 32'h2000);
    wr(OFF_CFG, 32'h00000002);
    wr(OFF_REF, 32'h0000E000);
    cyc(3);
    check({31'h0, reverseCmd}, 32'h0);
    check({16'h0, refMagnitude}, 32'h2000);
    wr(OFF_REF, 32'h00008001);
    cyc(3);
    check({16'h0, refMagnitude}, 32'h7FFF);
    wr(OFF_CTRL, 32'h00000408);
    wr(OFF_CFG, 32'h00000000);
    $display("test reverse done");

    tripIn <= 1'b1;
    cyc(8);
    rchk(OFF_STATUS, 32'h00000208);
    tripIn <= 1'b0;
    cyc(8);
    rchk(OFF_STATUS, 32'h00000208);
    check({31'h0, tripOut}, 32'h1);
    wr(OFF_CTRL, 32'h00000488);
    cyc(3);
    check({31'h0, tripOut}, 32'h0);
    wr(OFF_CTRL, 32'h00000488);
    wr(OFF_CTRL, 32'h00000408);
    wr(OFF_CTRL, 32'h00000088);
    cyc(3);
    check(nPulse, 32'h1);
    $display("test trip done");

    wr(OFF_CEIL, 32'h00000100);
    outCurrent <= 16'h0200;
    cyc(6);
    rchk(OFF_STATUS, 32'h00004205);
    check({31'h0, tripOut}, 32'h0);
    cyc(OCD + 10);
    check({31'h0, tripOut}, 32'h1);
    outCurrent <= 16'h0000;
    wr(OFF_CTRL, 32'h00000488);
    cyc(4);
    check({31'h0, tripOut}, 32'h0);
    rchk(OFF_STATUS, 32'h00000205);
    $display("test overcurrent done");

    coil(32'h00011020);
    check(v, 32'h00000012);
    rchk(OFF_COILRSP0, 32'h00000205);
    coil(32'h00010521);
    check(v, 32'h00000011);
    rchk(OFF_COILRSP0, 32'h00000002);
    coil(32'h01011020);
    check(v & 32'h00000090, 32'h00000080);
    coil(32'h00020820);
    check(v & 32'h00000040, 32'h00000040);
    for (int i = 0; i < 5; i++)
    begin
      coil({8'h00, i == 0 ? FC_FORCE_COIL : i == 1 ? FC_FORCE_COILS : i == 2 ? FC_READ_HOLD :
        i == 3 ? FC_PRESET_REG : FC_PRESET_REGS, 16'h0820});
      check(v & 32'h00000040, 32'h00000000);
    end
    coil(32'h00010020);
    check(v & 32'h00000020, 32'h00000020);
    coil(32'h0001083C);
    check(v & 32'h00000020, 32'h00000020);
    check({31'h0, hresp}, 32'h0);
    $display("test coils done");
    give_verdict();
  end
endmodule
